// *** rtl/flash_seq_pkg.sv ***
package flash_seq_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_NS       = 25;
   localparam int SETUP_NS     = 25;
   localparam int WE_PULSE_NS  = 35;
   localparam int HOLD_NS      = 25;
   localparam int ACCESS_NS    = 70;
   localparam int SYNC_STAGES  = 2;
   localparam int WINDOW_US    = 50;
   localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WE_CYC       = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC     = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_CYC     = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
   // Longest time, so rounded down
   localparam int WINDOW_CYC   = (WINDOW_US * 1000) / CLK_NS;

   // ****************************************************************
   // Addresses and offsets
   // ****************************************************************
   localparam logic [20:0] UNLOCK1_WORD = 21'h000555;
   localparam logic [20:0] UNLOCK2_WORD = 21'h0002aa;
   localparam logic [20:0] UNLOCK1_BYTE = 21'h000aaa;
   localparam logic [20:0] UNLOCK2_BYTE = 21'h000555;
   localparam logic [20:0] QUERY_WORD   = 21'h000055;
   localparam logic [20:0] QUERY_BYTE   = 21'h0000aa;
   localparam logic [20:0] MAKER_OFS    = 21'h000000;
   localparam logic [20:0] DEV_OFS_WORD = 21'h000001;
   localparam logic [20:0] DEV_OFS_BYTE = 21'h000002;
   localparam logic [20:0] PROT_OFS_WORD = 21'h000002;
   localparam logic [20:0] PROT_OFS_BYTE = 21'h000004;
   localparam logic [20:0] SECT_MASK_WORD = 21'h1ff000;
   localparam logic [20:0] SECT_MASK_BYTE = 21'h1fe000;

   // ****************************************************************
   // Command codes
   // ****************************************************************
   localparam logic [7:0] CODE_UNLOCK1  = 8'haa;
   localparam logic [7:0] CODE_UNLOCK2  = 8'h55;
   localparam logic [7:0] CODE_RESET    = 8'hf0;
   localparam logic [7:0] CODE_IDENT    = 8'h90;
   localparam logic [7:0] CODE_QUERY    = 8'h98;
   localparam logic [7:0] CODE_PROGRAM  = 8'ha0;
   localparam logic [7:0] CODE_BYPASS   = 8'h20;
   localparam logic [7:0] CODE_BYP_EXIT = 8'h00;
   localparam logic [7:0] CODE_ERASE    = 8'h80;
   localparam logic [7:0] CODE_CHIP     = 8'h10;
   localparam logic [7:0] CODE_SECTOR   = 8'h30;
   localparam logic [7:0] CODE_SUSPEND  = 8'hb0;
   localparam logic [7:0] CODE_RESUME   = 8'h30;
   localparam logic [1:0] ID_SEL_PROT   = 2'h2;
   localparam logic [1:0] ID_SEL_DEV    = 2'h1;

   typedef enum logic [3:0] {
      OP_READ, OP_RESET, OP_AUTOSEL, OP_QUERY, OP_PROGRAM, OP_BYP_ENTER,
      OP_BYP_EXIT, OP_CHIP_ERASE, OP_SECT_ERASE, OP_SECT_APPEND, OP_SUSPEND, OP_RESUME
   } op_e;

   typedef struct packed {
      logic        rd;
      logic        last;
      logic [20:0] addr;
      logic [15:0] data;
   } cyc_s;

endpackage

// *** rtl/bus_cycle_engine.sv ***
`timescale 1ns/1ps
module bus_cycle_engine
   import flash_seq_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        start,
   input  wire logic        is_read,
   input  wire logic [20:0] addr,
   input  wire logic [15:0] wdata,
   input  wire logic [15:0] dq_in,
   output logic             done,
   output logic [15:0]      rdata,
   output logic [20:0]      flash_addr,
   output logic [15:0]      dq_out,
   output logic             dq_oe,
   output logic             ce_n,
   output logic             we_n,
   output logic             oe_n
);
   typedef enum logic [2:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD, E_READ} eng_state_e;

   eng_state_e  state_q;
   logic [7:0]  cnt_q;
   logic        rd_q;
   logic [15:0] dq_s1_q;
   logic [15:0] dq_s2_q;

   // ****************************************************************
   // Data pin synchroniser
   // ****************************************************************
   always_ff @(posedge clock) begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
   end

   // ****************************************************************
   // Cycle sequencer
   // ****************************************************************
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_q    <= E_IDLE;
         cnt_q      <= 8'h00;
         rd_q       <= 1'b0;
         done       <= 1'b0;
         rdata      <= 16'h0000;
         flash_addr <= 21'h000000;
         dq_out     <= 16'h0000;
         dq_oe      <= 1'b0;
         ce_n       <= 1'b1;
         we_n       <= 1'b1;
         oe_n       <= 1'b1;
      end else begin
         done <= 1'b0;
         cnt_q <= cnt_q - 8'h01;
         case (state_q)
            E_IDLE: begin
               if (start) begin
                  flash_addr <= addr;
                  dq_out     <= wdata;
                  rd_q       <= is_read;
                  ce_n       <= 1'b0;
                  dq_oe      <= !is_read;
                  oe_n       <= !is_read;
                  cnt_q      <= is_read ? 8'(READ_CYC - 1) : 8'(SETUP_CYC - 1);
                  state_q    <= is_read ? E_READ : E_SETUP;
               end
            end
            E_SETUP: begin
               if (cnt_q == 8'h00) begin
                  // Chip enable already low, so this fall is the later one and latches the address
                  we_n    <= 1'b0;
                  cnt_q   <= 8'(WE_CYC - 1);
                  state_q <= E_PULSE;
               end
            end
            E_PULSE: begin
               if (cnt_q == 8'h00) begin
                  // Write enable rises first, so data is latched here while still driven
                  we_n    <= 1'b1;
                  cnt_q   <= 8'(HOLD_CYC - 1);
                  state_q <= E_HOLD;
               end
            end
            E_HOLD: begin
               if (cnt_q == 8'h00) begin
                  ce_n    <= 1'b1;
                  dq_oe   <= 1'b0;
                  done    <= 1'b1;
                  state_q <= E_IDLE;
               end
            end
            E_READ: begin
               if (cnt_q == 8'h00) begin
                  rdata   <= dq_s2_q;
                  ce_n    <= 1'b1;
                  oe_n    <= 1'b1;
                  done    <= 1'b1;
                  state_q <= E_IDLE;
               end
            end
            default: state_q <= E_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_ADDR_LATCH: assert property (@(posedge clock) disable iff (!resetn)
      $fell(we_n) |-> !ce_n && dq_oe && $stable(flash_addr))
      else $error("write strobe fell without chip enable and stable address");
   AST_DATA_LATCH: assert property (@(posedge clock) disable iff (!resetn)
      $rose(we_n) |-> !ce_n && dq_oe && $stable(dq_out) ##1 $rose(ce_n) && $fell(dq_oe))
      else $error("data not held across write strobe rise");
   AST_READ_SHAPE: assert property (@(posedge clock) disable iff (!resetn)
      $fell(oe_n) |-> !dq_oe && we_n)
      else $error("read cycle with bus driven");

endmodule // bus_cycle_engine

// *** rtl/flash_command_sequencer.sv ***
`timescale 1ns/1ps
// How it works
// - A plain read is one read cycle with no unlock or command writes.
// - Reset is one write of F0; it leaves identification and query modes.
// - All cycles are writes except plain read and the fourth identification cycle.
// - Identification, program, bypass entry and erase open with AA then 55 at mode's unlock addresses; upper data byte zero.
// - Identification: unlock, 90, then read maker or device code offset.
// - Program: unlock, A0, then value to target address.
// - Bypass mode entered by unlock then 20; needed before bypass program.
// - Bypass program is A0 then value to target, no unlock cycles.
// - Bypass exit is 90 then 00 to any address.
// - Erase: unlock, 80, unlock, then 10 for chip or 30 to sector.
module flash_command_sequencer
   import flash_seq_pkg::*;
#(
   parameter int ADDR_W = 21
)(
   input  wire logic              clock,
   input  wire logic              resetn,
   input  wire logic              cmd_valid,
   input  wire op_e               cmd_op,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [15:0]       cmd_data,
   input  wire logic              cmd_byte_mode,
   output logic                   cmd_ready,
   output logic                   cmd_error,
   output logic                   rd_valid,
   output logic [15:0]            rd_data,
   output logic                   bypass_mode,
   output logic                   erase_suspended,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic [15:0]            dq_out,
   output logic                   dq_oe,
   input  wire logic [15:0]       dq_in,
   output logic                   ce_n,
   output logic                   we_n,
   output logic                   oe_n,
   output logic                   flash_reset_n,
   input  wire logic              ready_busy_n
);
   typedef enum logic [1:0] {S_IDLE, S_RUN, S_WAIT} seq_state_e;

   seq_state_e  state_q;
   op_e         op_q;
   logic [20:0] addr_q;
   logic [15:0] data_q;
   logic        bm_q;
   logic [2:0]  step_q;
   logic        start_q;
   logic        id_mode_q;
   logic        query_q;
   logic        sect_erase_q;
   logic [11:0] window_q;
   logic        rb_s1_q;
   logic        rb_s2_q;
   logic        rb_prev_q;
   logic        eng_done;
   logic        accept;
   cyc_s        cyc;

   // ****************************************************************
   // Sequence table
   // ****************************************************************
   function automatic cyc_s seq_cycle(op_e op, logic [2:0] st, logic bm, logic byp,
                                      logic [20:0] a, logic [15:0] d);
      cyc_s        c;
      logic [20:0] u1;
      logic [20:0] u2;
      logic [20:0] sa;
      logic [20:0] ofs;
      u1  = bm ? UNLOCK1_BYTE : UNLOCK1_WORD;
      u2  = bm ? UNLOCK2_BYTE : UNLOCK2_WORD;
      sa  = a & (bm ? SECT_MASK_BYTE : SECT_MASK_WORD);
      ofs = (d[1:0] == ID_SEL_DEV) ? (bm ? DEV_OFS_BYTE : DEV_OFS_WORD) : MAKER_OFS;
      if (d[1:0] == ID_SEL_PROT)
         ofs = sa | (bm ? PROT_OFS_BYTE : PROT_OFS_WORD);
      // Upper data byte stays zero on unlock and command cycles, upper address bits too except on the 30 to sector
      c = '{rd: 1'b0, last: 1'b0, addr: u1, data: {8'h00, CODE_UNLOCK1}};
      if (st == 3'd1 || st == 3'd4) begin
         c.addr = u2;
         c.data = {8'h00, CODE_UNLOCK2};
      end
      case (op)
         OP_READ:        c = '{rd: 1'b1, last: 1'b1, addr: a, data: 16'h0000};
         OP_RESET:       c = '{rd: 1'b0, last: 1'b1, addr: 21'h0, data: {8'h00, CODE_RESET}};
         OP_QUERY:       c = '{rd: 1'b0, last: 1'b1, addr: bm ? QUERY_BYTE : QUERY_WORD,
                               data: {8'h00, CODE_QUERY}};
         OP_SUSPEND:     c = '{rd: 1'b0, last: 1'b1, addr: 21'h0, data: {8'h00, CODE_SUSPEND}};
         OP_RESUME:      c = '{rd: 1'b0, last: 1'b1, addr: 21'h0, data: {8'h00, CODE_RESUME}};
         OP_SECT_APPEND: c = '{rd: 1'b0, last: 1'b1, addr: sa, data: {8'h00, CODE_SECTOR}};
         OP_AUTOSEL: begin
            if (st == 3'd2) c.data = {8'h00, CODE_IDENT};
            if (st == 3'd3) c = '{rd: 1'b1, last: 1'b1, addr: ofs, data: 16'h0000};
         end
         OP_PROGRAM: begin
            if (byp) begin
               c = '{rd: 1'b0, last: 1'b0, addr: 21'h0, data: {8'h00, CODE_PROGRAM}};
               if (st == 3'd1) c = '{rd: 1'b0, last: 1'b1, addr: a, data: d};
            end else begin
               if (st == 3'd2) c.data = {8'h00, CODE_PROGRAM};
               if (st == 3'd3) c = '{rd: 1'b0, last: 1'b1, addr: a, data: d};
            end
         end
         OP_BYP_ENTER: begin
            if (st == 3'd2) c = '{rd: 1'b0, last: 1'b1, addr: u1, data: {8'h00, CODE_BYPASS}};
         end
         OP_BYP_EXIT: begin
            c = '{rd: 1'b0, last: (st == 3'd1), addr: 21'h0,
                  data: {8'h00, (st == 3'd1) ? CODE_BYP_EXIT : CODE_IDENT}};
         end
         OP_CHIP_ERASE, OP_SECT_ERASE: begin
            if (st == 3'd2) c.data = {8'h00, CODE_ERASE};
            if (st == 3'd5) begin
               c.last = 1'b1;
               c.addr = (op == OP_SECT_ERASE) ? sa : u1;
               c.data = {8'h00, (op == OP_SECT_ERASE) ? CODE_SECTOR : CODE_CHIP};
            end
         end
         default: c.last = 1'b1;
      endcase
      return c;
   endfunction

   // Only sequences the device is known to honour in its current mode are sent
   function automatic logic op_legal(op_e op, logic byp, logic susp, logic sect, logic win,
                                     logic idm, logic qry);
      if (byp)
         return op == OP_PROGRAM || op == OP_BYP_EXIT || op == OP_READ;
      case (op)
         OP_QUERY:       return !qry && !sect || idm;
         OP_SUSPEND:     return sect && !susp;
         OP_RESUME:      return susp;
         OP_SECT_APPEND: return win && !susp;
         OP_BYP_EXIT:    return 1'b0;
         OP_BYP_ENTER, OP_CHIP_ERASE, OP_SECT_ERASE: return !sect;
         default:        return !sect || susp || op == OP_RESET;
      endcase
   endfunction

   assign cyc    = seq_cycle(op_q, step_q, bm_q, bypass_mode, addr_q, data_q);
   assign accept = cmd_valid && cmd_ready;

   // ****************************************************************
   // Command sequencing
   // ****************************************************************
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_q   <= S_IDLE;
         op_q      <= OP_READ;
         addr_q    <= 21'h000000;
         data_q    <= 16'h0000;
         bm_q      <= 1'b0;
         step_q    <= 3'd0;
         start_q   <= 1'b0;
         cmd_ready <= 1'b0;
         cmd_error <= 1'b0;
         rd_valid  <= 1'b0;
      end else begin
         start_q   <= 1'b0;
         cmd_error <= 1'b0;
         rd_valid  <= 1'b0;
         case (state_q)
            S_IDLE: begin
               cmd_ready <= 1'b1;
               if (accept) begin
                  cmd_ready <= 1'b0;
                  op_q      <= cmd_op;
                  addr_q    <= 21'(cmd_addr);
                  data_q    <= cmd_data;
                  bm_q      <= cmd_byte_mode;
                  step_q    <= 3'd0;
                  if (op_legal(cmd_op, bypass_mode, erase_suspended, sect_erase_q, window_q != 12'h000,
                               id_mode_q, query_q)) begin
                     start_q <= 1'b1;
                     state_q <= S_WAIT;
                  end else begin
                     // Refused instead of sent, a stray write would abort the device's sequence
                     cmd_error <= 1'b1;
                  end
               end
            end
            S_RUN: begin
               start_q <= 1'b1;
               state_q <= S_WAIT;
            end
            S_WAIT: begin
               if (eng_done) begin
                  if (cyc.last) begin
                     rd_valid <= cyc.rd;
                     state_q  <= S_IDLE;
                  end else begin
                     step_q  <= step_q + 3'd1;
                     state_q <= S_RUN;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Device mode tracking
   // ****************************************************************
   logic seq_end;
   assign seq_end = (state_q == S_WAIT) && eng_done && cyc.last;

   always_ff @(posedge clock) begin
      if (!resetn) begin
         id_mode_q       <= 1'b0;
         query_q         <= 1'b0;
         bypass_mode     <= 1'b0;
         sect_erase_q    <= 1'b0;
         erase_suspended <= 1'b0;
         window_q        <= 12'h000;
         flash_reset_n   <= 1'b0;
      end else begin
         flash_reset_n <= 1'b1;
         if (window_q != 12'h000)
            window_q <= window_q - 12'h001;
         // Busy to ready edge ends a running erase
         if (rb_s2_q && !rb_prev_q && !erase_suspended && window_q == 12'h000)
            sect_erase_q <= 1'b0;
         if (seq_end) begin
            case (op_q)
               OP_RESET:      begin id_mode_q <= 1'b0; query_q <= 1'b0; end
               OP_AUTOSEL:    id_mode_q <= 1'b1;
               OP_QUERY:      query_q <= 1'b1;
               OP_BYP_ENTER:  bypass_mode <= 1'b1;
               OP_BYP_EXIT:   bypass_mode <= 1'b0;
               OP_SECT_ERASE, OP_SECT_APPEND: begin
                  sect_erase_q <= 1'b1;
                  // Two clocks pass from the strobe rise to here and four from accept to the next rise
                  window_q     <= 12'(WINDOW_CYC - 6);
               end
               OP_SUSPEND:    begin erase_suspended <= 1'b1; window_q <= 12'h000; end
               OP_RESUME:     erase_suspended <= 1'b0;
               default:       id_mode_q <= id_mode_q;
            endcase
         end
      end
   end

   // ****************************************************************
   // Ready/busy pin synchroniser
   // ****************************************************************
   always_ff @(posedge clock) begin
      rb_s1_q   <= ready_busy_n;
      rb_s2_q   <= rb_s1_q;
      rb_prev_q <= rb_s2_q;
   end

   bus_cycle_engine u_engine (
      .clock      (clock),
      .resetn     (resetn),
      .start      (start_q),
      .is_read    (cyc.rd),
      .addr       (cyc.addr),
      .wdata      (cyc.data),
      .dq_in      (dq_in),
      .done       (eng_done),
      .rdata      (rd_data),
      .flash_addr (flash_addr),
      .dq_out     (dq_out),
      .dq_oe      (dq_oe),
      .ce_n       (ce_n),
      .we_n       (we_n),
      .oe_n       (oe_n)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_READ_DIRECT: assert property (@(posedge clock) disable iff (!resetn)
      start_q && op_q == OP_READ |-> cyc.rd && cyc.last && step_q == 3'd0 && cyc.addr == addr_q)
      else $error("plain read not a single read cycle");
   AST_RESET_CODE: assert property (@(posedge clock) disable iff (!resetn)
      seq_end && op_q == OP_RESET |=> !id_mode_q && !query_q)
      else $error("reset did not leave identification or query mode");
   AST_READ_ONLY_ID4: assert property (@(posedge clock) disable iff (!resetn)
      start_q && cyc.rd |-> op_q == OP_READ || (op_q == OP_AUTOSEL && step_q == 3'd3))
      else $error("read cycle inside a command sequence");
   AST_UNLOCK_PAIR: assert property (@(posedge clock) disable iff (!resetn)
      start_q && step_q == 3'd0 && op_q inside {OP_AUTOSEL, OP_CHIP_ERASE, OP_SECT_ERASE, OP_BYP_ENTER}
      |-> cyc.data == 16'h00aa ##[1:20] start_q && cyc.data == 16'h0055)
      else $error("unlock pair malformed");
   AST_ID_ENTRY: assert property (@(posedge clock) disable iff (!resetn)
      start_q && op_q == OP_AUTOSEL && step_q == 3'd2 |-> cyc.data == 16'h0090 ##[1:20] start_q && cyc.rd)
      else $error("identification entry malformed");
   AST_PROG_FOUR: assert property (@(posedge clock) disable iff (!resetn)
      start_q && op_q == OP_PROGRAM && !bypass_mode && step_q == 3'd2 |-> cyc.data == 16'h00a0 && !cyc.last)
      else $error("program setup cycle wrong");
   AST_BYPASS_ENTRY: assert property (@(posedge clock) disable iff (!resetn)
      $rose(bypass_mode) |-> $past(op_q) == OP_BYP_ENTER && $past(step_q) == 3'd2)
      else $error("bypass mode entered without its sequence");
   AST_BYPASS_PROG: assert property (@(posedge clock) disable iff (!resetn)
      start_q && op_q == OP_PROGRAM && bypass_mode |-> step_q <= 3'd1 && (step_q == 3'd1) == cyc.last)
      else $error("bypass program not two cycles");
   AST_BYPASS_EXIT: assert property (@(posedge clock) disable iff (!resetn)
      start_q && op_q == OP_BYP_EXIT && step_q == 3'd1 |-> cyc.data == 16'h0000 ##[1:20] !bypass_mode)
      else $error("bypass exit malformed");
   AST_ERASE_LAST: assert property (@(posedge clock) disable iff (!resetn)
      start_q && op_q == OP_SECT_ERASE && step_q == 3'd5 |-> cyc.data == 16'h0030 && cyc.last)
      else $error("sector erase final cycle wrong");
   AST_APPEND_WINDOW: assert property (@(posedge clock) disable iff (!resetn)
      start_q && op_q == OP_SECT_APPEND |-> $past(window_q) != 12'h000)
      else $error("sector append outside the window");

endmodule // flash_command_sequencer

// *** testbench/flash_device_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Word-mode flash device, behavioural
// ****************************************************************
module flash_device_model
   import flash_seq_pkg::*;
#(
   parameter logic [15:0] MAKER_CODE  = 16'h00a5, // Arbitrary
   parameter logic [15:0] DEVICE_CODE = 16'h1b3c  // Arbitrary
)(
   input  wire logic [20:0] flash_addr,
   input  wire logic [15:0] dq_out,
   output logic [15:0]      dq_in,
   input  wire logic        ce_n,
   input  wire logic        we_n,
   input  wire logic        oe_n,
   output logic             ready_busy_n
);
   logic [15:0] mem [256];
   logic [20:0] la;
   logic [15:0] rd;
   logic [7:0]  d;
   int          step = 0;
   logic        id   = 1'b0;
   logic        byp  = 1'b0;
   logic        qry  = 1'b0;
   initial foreach (mem[i]) mem[i] = 16'hffff;
   // Pull-up only: embedded algorithm timing is not modelled
   assign ready_busy_n = 1'b1;
   assign rd = qry ? ~mem[flash_addr[7:0]] : // Query table stand-in, arbitrary
               id ? (flash_addr[1:0] == 2'h0 ? MAKER_CODE : flash_addr[1:0] == 2'h1 ? DEVICE_CODE
                                                                                    : 16'h0000)
                  : mem[flash_addr[7:0]];
   // Released bus shows the inverse, so a stale capture cannot pass
   assign dq_in = (!ce_n && !oe_n) ? rd : ~rd;
   always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) la = flash_addr;
   always @(posedge we_n or posedge ce_n) begin
      d = dq_out[7:0];
      if (we_n != ce_n) begin
         if (d == 8'hf0) begin
            step = 0;
            id   = 1'b0;
            qry  = 1'b0;
         end else begin
            if (step == 0 && !byp && la[10:0] == 11'h055 && d == 8'h98) qry = 1'b1;
            case (step)
               0: step = byp ? (d == 8'ha0 ? 5 : d == 8'h90 ? 6 : 0)
                             : (la[10:0] == 11'h555 && d == 8'haa) ? 1 : 0;
               1: step = (la[10:0] == 11'h2aa && d == 8'h55) ? 2 : 0;
               2: begin
                  id   = (d == 8'h90);
                  byp  = (d == 8'h20);
                  step = (d == 8'ha0) ? 5 : 0;
               end
               5: begin
                  mem[la[7:0]] &= dq_out;
                  step = 0;
               end
               6: begin
                  byp  = (d != 8'h00);
                  step = 0;
               end
               default: step = 0;
            endcase
         end
      end
   end
endmodule // flash_device_model

// *** testbench/test_flash_command_sequencer.sv ***
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
// ****************************************************************
// Bench
// ****************************************************************
module test_flash_command_sequencer;
   import flash_seq_pkg::*;
   localparam logic [15:0] MAKER = 16'h00a5; // Arbitrary
   localparam logic [15:0] DEVID = 16'h1b3c; // Arbitrary
   logic        clock = 0, resetn = 0, cmd_valid = 0, cmd_byte_mode = 0, err = 0;
   op_e         cmd_op = OP_READ;
   logic [20:0] cmd_addr = 21'h0, flash_addr;
   logic [15:0] cmd_data = 16'h0, rd_data, dq_out, dq_in, got;
   logic        cmd_ready, cmd_error, rd_valid, bypass_mode, erase_suspended, dq_oe, ce_n, we_n, oe_n;
   logic        flash_reset_n, ready_busy_n;
   int          fail_count = 0, n_tests = 0;
   always #12.5 clock = ~clock;
   flash_command_sequencer i_dut (.clock, .resetn, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_byte_mode,
      .cmd_ready, .cmd_error, .rd_valid, .rd_data, .bypass_mode, .erase_suspended, .flash_addr, .dq_out, .dq_oe,
      .dq_in, .ce_n, .we_n, .oe_n, .flash_reset_n, .ready_busy_n);
   flash_device_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID)) i_flash (.flash_addr, .dq_out, .dq_in, .ce_n,
      .we_n, .oe_n, .ready_busy_n);
   always @(posedge clock) begin
      if (rd_valid) got <= rd_data;
      if (cmd_error) err <= 1'b1;
   end
   task automatic op(input op_e o, input logic [20:0] a, input logic [15:0] dv);
      int n;
      for (n = 0; n < 500 && cmd_ready !== 1'b1; n++) @(negedge clock);
      if (n == 500) fail_count++;
      cmd_valid = 1; cmd_op = o; cmd_addr = a; cmd_data = dv; err = 0;
      @(negedge clock);
      cmd_valid = 0;
      for (n = 0; n < 500 && cmd_ready !== 1'b1; n++) @(negedge clock);
      if (n == 500) fail_count++;
      @(negedge clock);
   endtask
   task automatic t_plain;
      op(OP_READ, 21'h10, 16'h0);
      `CHK("erased read", 16'hffff, got)
      op(OP_PROGRAM, 21'h10, 16'h1234);
      op(OP_READ, 21'h10, 16'h0);
      `CHK("program", 16'h1234, got)
   endtask
   task automatic t_ident;
      op(OP_AUTOSEL, 21'h0, 16'h0);
      `CHK("maker", MAKER, got)
      op(OP_AUTOSEL, 21'h0, 16'h1);
      `CHK("device", DEVID, got)
      op(OP_AUTOSEL, 21'h3000, 16'h2);
      `CHK("protect", 16'h0000, got)
      op(OP_RESET, 21'h0, 16'h0);
      op(OP_READ, 21'h10, 16'h0);
      `CHK("after reset", 16'h1234, got)
      op(OP_QUERY, 21'h0, 16'h0);
      op(OP_QUERY, 21'h0, 16'h0);
      `CHK("query twice", 1'b1, err)
      op(OP_READ, 21'h10, 16'h0);
      `CHK("query read", 16'hedcb, got)
      op(OP_RESET, 21'h0, 16'h0);
   endtask
   task automatic t_bypass;
      op(OP_BYP_ENTER, 21'h0, 16'h0);
      `CHK("bypass on", 1'b1, bypass_mode)
      op(OP_AUTOSEL, 21'h0, 16'h0);
      `CHK("bypass refuse", 1'b1, err)
      op(OP_PROGRAM, 21'h20, 16'h00ff);
      op(OP_BYP_EXIT, 21'h0, 16'h0);
      `CHK("bypass off", 1'b0, bypass_mode)
      op(OP_READ, 21'h20, 16'h0);
      `CHK("bypass program", 16'h00ff, got)
   endtask
   task automatic t_refuse;
      op(OP_BYP_EXIT, 21'h0, 16'h0);
      `CHK("exit refused", 1'b1, err)
      op(OP_SUSPEND, 21'h0, 16'h0);
      `CHK("suspend refused", 1'b1, err)
      op(OP_RESUME, 21'h0, 16'h0);
      `CHK("resume refused", 1'b1, err)
      `CHK("not suspended", 1'b0, erase_suspended)
   endtask
   task automatic t_erase;
      op(OP_SECT_ERASE, 21'h3000, 16'h0);
      op(OP_SECT_APPEND, 21'h5000, 16'h0);
      `CHK("append", 1'b0, err)
      op(OP_SUSPEND, 21'h0, 16'h0);
      `CHK("suspended", 1'b1, erase_suspended)
      op(OP_SECT_APPEND, 21'h5000, 16'h0);
      `CHK("append refused", 1'b1, err)
      op(OP_READ, 21'h10, 16'h0);
      `CHK("suspended read", 16'h1234, got)
      op(OP_RESUME, 21'h0, 16'h0);
      `CHK("resumed", 1'b0, erase_suspended)
      op(OP_READ, 21'h10, 16'h0);
      `CHK("erasing read refused", 1'b1, err)
   endtask
   task automatic complete_run;
      if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #2000000;
      fail_count++;
      complete_run;
   end
   initial begin
      repeat (3) @(negedge clock);
      `CHK("flash reset held", 1'b0, flash_reset_n)
      resetn = 1;
      repeat (2) @(negedge clock);
      `CHK("flash reset released", 1'b1, flash_reset_n)
      t_plain;
      t_ident;
      t_bypass;
      t_refuse;
      t_erase;
      complete_run;
   end
endmodule // test_flash_command_sequencer
